/* common/lim_map.svh */
// Constants of the literal and indirect move decoder: opcodes, fields,
// register offsets and reset values. Assumes inclusion by bare name.
`ifndef LIM_MAP_SVH
`define LIM_MAP_SVH

// Opcode patterns of the 14-bit instruction word
`define LIM_NOP_CODE 14'h0000
`define LIM_SRST_CODE 14'h0001
`define LIM_IND_MASK 14'h3ff8
`define LIM_IND_CODE 14'h0010
`define LIM_STF_MASK 14'h3f80
`define LIM_STF_CODE 14'h0080
`define LIM_LB_MASK 14'h3fc0
`define LIM_LB_CODE 14'h0140
`define LIM_LW_MASK 14'h3f00
`define LIM_LW_CODE 14'h3000
`define LIM_LP_MASK 14'h3f80
`define LIM_LP_CODE 14'h3180
`define LIM_REL_MASK 14'h3f80
`define LIM_REL_CODE 14'h3f00

// Instruction fields
`define LIM_F_K6 5:0
`define LIM_F_K7 6:0
`define LIM_F_K8 7:0
`define LIM_F_OFS 5:0
`define LIM_F_PTR 15:0
`define LIM_F_PC 14:0
`define LIM_B_SEL 2
`define LIM_B_RSEL 6
`define LIM_B_POST 1
`define LIM_B_DEC 0
`define LIM_B_FLAG 0

// Register byte offsets
`define LIM_AW 8
`define LIM_A_CTRL 8'h00
`define LIM_A_ACC 8'h04
`define LIM_A_BANK 8'h08
`define LIM_A_PAGE 8'h0c
`define LIM_A_PTR0 8'h10
`define LIM_A_STEP 8'h04
`define LIM_A_PWR 8'h18
`define LIM_A_STAT 8'h1c
`define LIM_A_PC 8'h20

// Reset values
`define LIM_RST_RUN 1'h1
`define LIM_RST_ACC 8'h00
`define LIM_RST_BANK 6'h00
`define LIM_RST_PAGE 7'h00
`define LIM_RST_PTR 16'h0000
`define LIM_RST_FLAG 1'h1
`define LIM_RST_STAT 8'h00
`define LIM_RST_PC 15'h0000

`endif

/* common/lim_pkg.sv */
// Types shared by the literal and indirect move decoder.
// Assumes nothing of its surroundings.
`default_nettype none

package lim_pkg;
	typedef enum logic [3:0] {
		OP_NONE, OP_NOOP, OP_SRST, OP_LOAD_BANK, OP_LOAD_PAGE,
		OP_LOAD_ACC, OP_STORE_FILE, OP_STORE_IND, OP_STORE_REL
	} lim_op_e;

	// One data memory write, direct or through a pointer
	typedef struct packed {
		logic valid;
		logic indirect;
		logic [15:0] addr;
		logic [7:0] data;
	} lim_wr_s;
endpackage

`default_nettype wire

/* hw/lim_core.sv */
// Execution of literal loads, accumulator stores, indirect stores through
// two 16-bit pointers, no-operation and software reset.
// Assumes a same-clock instruction feed and one AHB-Lite master.
//
// Added by the designer: the AHB-Lite register port and the placing of the registers.
`include "lim_map.svh"
`default_nettype none

// Contract
// - Bank literal loads bank select, flags kept
// - Page literal loads page latch, flags kept
// - Accumulator literal loads accumulator, flags kept
// - Store copies accumulator to addressed file
// - Mode 00 preinc, 01 predec, 10/11 post
// - Relative form addresses pointer plus offset
// - Pointer ends incremented, decremented or unchanged
// - Indirect window redirects to pointer address
// - Pointers wrap modulo 16 bits
// - Indirect store changes no status flag
// - Selector picks one of two pointers
// - Software reset resets, clears reset flag
module lim_core #(
	parameter int NPTR = 2
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic sys_rst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Instruction stream
	input wire logic instr_valid,
	input wire logic [13:0] instr_word,
	output logic instr_ready,
	// Data memory write port
	output lim_pkg::lim_wr_s mem_wr,
	// Software reset request to the rest of the device
	output logic soft_rst_pulse
);

	// Two pointers are hard-wired into the selector bit
	if (NPTR != 2) begin : g_chk
		$error("NPTR must be 2");
	end

	lim_pkg::lim_op_e op;
	logic accept, exec_srst, exec_ind, sel, is_rel;
	logic run_q, flag_q, dph_q, done_q, wr_q;
	logic [7:0] acc_q, stat_q;
	logic [5:0] bank_q;
	logic [6:0] page_q;
	logic [14:0] pc_q;
	logic [15:0] ptr_q [NPTR];
	logic [15:0] sel_ptr, ptr_new, ofs, ea;
	logic [`LIM_AW-1:0] adr_q;
	logic [31:0] rd_d;
	logic bus_wr, bus_rd;

	// Opcode decode; unknown words execute as nothing
	always_comb begin
		op = lim_pkg::OP_NONE;
		if (instr_word == `LIM_NOP_CODE) begin
			op = lim_pkg::OP_NOOP;
		end else if (instr_word == `LIM_SRST_CODE) begin
			op = lim_pkg::OP_SRST;
		end else if ((instr_word & `LIM_IND_MASK) == `LIM_IND_CODE) begin
			op = lim_pkg::OP_STORE_IND;
		end else if ((instr_word & `LIM_STF_MASK) == `LIM_STF_CODE) begin
			op = lim_pkg::OP_STORE_FILE;
		end else if ((instr_word & `LIM_LB_MASK) == `LIM_LB_CODE) begin
			op = lim_pkg::OP_LOAD_BANK;
		end else if ((instr_word & `LIM_LW_MASK) == `LIM_LW_CODE) begin
			op = lim_pkg::OP_LOAD_ACC;
		end else if ((instr_word & `LIM_LP_MASK) == `LIM_LP_CODE) begin
			op = lim_pkg::OP_LOAD_PAGE;
		end else if ((instr_word & `LIM_REL_MASK) == `LIM_REL_CODE) begin
			op = lim_pkg::OP_STORE_REL;
		end
	end

	// One instruction per cycle while running, no stall inside
	assign instr_ready = run_q;
	assign accept = instr_valid & run_q;
	assign exec_srst = accept && op == lim_pkg::OP_SRST;
	assign is_rel = op == lim_pkg::OP_STORE_REL;
	assign exec_ind = accept && (op == lim_pkg::OP_STORE_IND || is_rel);

	// Pointer selection and effective address
	assign sel = is_rel ? instr_word[`LIM_B_RSEL] : instr_word[`LIM_B_SEL];
	assign sel_ptr = ptr_q[sel];
	assign ofs = 16'(signed'(instr_word[`LIM_F_OFS]));
	// Natural 16-bit overflow gives the wrap at both ends
	assign ptr_new = instr_word[`LIM_B_DEC] ? sel_ptr - 16'h0001 : sel_ptr + 16'h0001;
	always_comb begin
		if (is_rel) begin
			ea = sel_ptr + ofs;
		end else if (instr_word[`LIM_B_POST]) begin
			ea = sel_ptr;
		end else begin
			ea = ptr_new;
		end
	end

	// Accumulator
	always_ff @(posedge mclk) begin
		if (sys_rst || exec_srst) begin
			acc_q <= `LIM_RST_ACC;
		end else if (accept && op == lim_pkg::OP_LOAD_ACC) begin
			acc_q <= instr_word[`LIM_F_K8];
		end else if (bus_wr && adr_q == `LIM_A_ACC) begin
			acc_q <= hwdata[`LIM_F_K8];
		end
	end

	// Bank select
	always_ff @(posedge mclk) begin
		if (sys_rst || exec_srst) begin
			bank_q <= `LIM_RST_BANK;
		end else if (accept && op == lim_pkg::OP_LOAD_BANK) begin
			bank_q <= instr_word[`LIM_F_K6];
		end else if (bus_wr && adr_q == `LIM_A_BANK) begin
			bank_q <= hwdata[`LIM_F_K6];
		end
	end

	// Page latch
	always_ff @(posedge mclk) begin
		if (sys_rst || exec_srst) begin
			page_q <= `LIM_RST_PAGE;
		end else if (accept && op == lim_pkg::OP_LOAD_PAGE) begin
			page_q <= instr_word[`LIM_F_K7];
		end else if (bus_wr && adr_q == `LIM_A_PAGE) begin
			page_q <= hwdata[`LIM_F_K7];
		end
	end

	// Pointers; the relative form leaves its pointer alone
	for (genvar i = 0; i < NPTR; i++) begin : g_ptr
		always_ff @(posedge mclk) begin
			if (sys_rst || exec_srst) begin
				ptr_q[i] <= `LIM_RST_PTR;
			end else if (exec_ind && !is_rel && sel == 1'(i)) begin
				ptr_q[i] <= ptr_new;
			end else if (bus_wr && adr_q == `LIM_AW'(`LIM_A_PTR0 + i * `LIM_A_STEP)) begin
				ptr_q[i] <= hwdata[`LIM_F_PTR];
			end
		end
	end

	// Status flags: no instruction of this group but the software reset touches them
	always_ff @(posedge mclk) begin
		if (sys_rst || exec_srst) begin
			stat_q <= `LIM_RST_STAT;
		end else if (bus_wr && adr_q == `LIM_A_STAT) begin
			stat_q <= hwdata[`LIM_F_K8];
		end
	end

	// Program counter, one step per instruction
	always_ff @(posedge mclk) begin
		if (sys_rst || exec_srst) begin
			pc_q <= `LIM_RST_PC;
		end else if (accept) begin
			pc_q <= pc_q + 15'h0001;
		end
	end

	// Reset cause flag; the system reset set beats the software reset clear
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			flag_q <= `LIM_RST_FLAG;
		end else if (exec_srst) begin
			flag_q <= 1'b0;
		end else if (bus_wr && adr_q == `LIM_A_PWR) begin
			flag_q <= hwdata[`LIM_B_FLAG];
		end
	end

	// Run enable survives a software reset so the core restarts at once
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			run_q <= `LIM_RST_RUN;
		end else if (bus_wr && adr_q == `LIM_A_CTRL) begin
			run_q <= hwdata[`LIM_B_FLAG];
		end
	end

	// Software reset pulse to the rest of the device
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			soft_rst_pulse <= 1'b0;
		end else begin
			soft_rst_pulse <= exec_srst;
		end
	end

	// Data memory writes; the window has no storage, it becomes an address
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			mem_wr <= '0;
		end else begin
			mem_wr.valid <= exec_ind || (accept && op == lim_pkg::OP_STORE_FILE);
			mem_wr.indirect <= exec_ind;
			mem_wr.addr <= exec_ind ? ea : 16'({bank_q, instr_word[`LIM_F_K7]});
			mem_wr.data <= acc_q;
		end
	end

	// Bus phases: one wait state so reads see the previous write
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			dph_q <= 1'b0;
			done_q <= 1'b0;
			wr_q <= 1'b0;
			adr_q <= '0;
		end else if (hreadyout) begin
			dph_q <= hsel & htrans[1] & hready;
			done_q <= 1'b0;
			wr_q <= hwrite;
			adr_q <= haddr[`LIM_AW-1:0];
		end else begin
			done_q <= 1'b1;
		end
	end

	assign hreadyout = ~dph_q | done_q;
	assign hresp = 1'b0; // Always OKAY; size is taken as a word
	assign bus_wr = dph_q & ~done_q & wr_q;
	assign bus_rd = dph_q & ~done_q & ~wr_q;

	// Read mux; unmapped offsets and unused bits read zero
	always_comb begin
		rd_d = 32'h0;
		if (adr_q == `LIM_A_CTRL) begin
			rd_d[`LIM_B_FLAG] = run_q;
		end else if (adr_q == `LIM_A_ACC) begin
			rd_d[`LIM_F_K8] = acc_q;
		end else if (adr_q == `LIM_A_BANK) begin
			rd_d[`LIM_F_K6] = bank_q;
		end else if (adr_q == `LIM_A_PAGE) begin
			rd_d[`LIM_F_K7] = page_q;
		end else if (adr_q == `LIM_A_PTR0) begin
			rd_d[`LIM_F_PTR] = ptr_q[0];
		end else if (adr_q == `LIM_AW'(`LIM_A_PTR0 + `LIM_A_STEP)) begin
			rd_d[`LIM_F_PTR] = ptr_q[1];
		end else if (adr_q == `LIM_A_PWR) begin
			rd_d[`LIM_B_FLAG] = flag_q;
		end else if (adr_q == `LIM_A_STAT) begin
			rd_d[`LIM_F_K8] = stat_q;
		end else if (adr_q == `LIM_A_PC) begin
			rd_d[`LIM_F_PC] = pc_q;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			hrdata <= 32'h0;
		end else if (bus_rd) begin
			hrdata <= rd_d;
		end
	end

	// Checks
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);

	sequence srst_seq;
		// A second reset word taken right away legally keeps the pulse up
		soft_rst_pulse && !flag_q ##1 (!soft_rst_pulse || $past(exec_srst));
	endsequence

	bank_load_a: assert property (accept && op == lim_pkg::OP_LOAD_BANK |=>
		bank_q == $past(instr_word[`LIM_F_K6])) else $error("bank literal not loaded");
	page_load_a: assert property (accept && op == lim_pkg::OP_LOAD_PAGE |=>
		page_q == $past(instr_word[`LIM_F_K7])) else $error("page literal not loaded");
	acc_load_a: assert property (accept && op == lim_pkg::OP_LOAD_ACC |=>
		acc_q == $past(instr_word[`LIM_F_K8])) else $error("acc literal not loaded");
	file_store_a: assert property (accept && op == lim_pkg::OP_STORE_FILE |=>
		mem_wr.valid && !mem_wr.indirect && mem_wr.data == $past(acc_q)
		&& mem_wr.addr[`LIM_F_K7] == $past(instr_word[`LIM_F_K7])) else $error("file store wrong");
	pre_inc_a: assert property (exec_ind && !is_rel && instr_word[`LIM_B_POST:`LIM_B_DEC] == 2'h0 |=>
		mem_wr.valid && mem_wr.indirect && mem_wr.addr == $past(sel_ptr) + 16'h1)
		else $error("preincrement address wrong");
	rel_ofs_a: assert property (exec_ind && is_rel && !sel && !bus_wr |=>
		ptr_q[0] == $past(ptr_q[0]) && mem_wr.addr == $past(ptr_q[0] + ofs)) else $error("relative form wrong");
	post_dec_a: assert property (exec_ind && !is_rel && !sel && instr_word[`LIM_B_POST:`LIM_B_DEC] == 2'h3 |=>
		ptr_q[0] == $past(ptr_q[0]) - 16'h1 && mem_wr.addr == $past(ptr_q[0])) else $error("postdecrement wrong");
	ptr_wrap_a: assert property (exec_ind && !is_rel && sel && ptr_q[1] == 16'hffff &&
		instr_word[`LIM_B_POST:`LIM_B_DEC] == 2'h2 |=> ptr_q[1] == 16'h0) else $error("pointer did not wrap");
	other_ptr_a: assert property (exec_ind && !sel && !bus_wr |=>
		$stable(ptr_q[1])) else $error("unselected pointer moved");
	flags_kept_a: assert property (accept && !exec_srst && !bus_wr |=>
		$stable(stat_q)) else $error("status changed by instruction");
	soft_rst_a: assert property (exec_srst |=> srst_seq and acc_q == `LIM_RST_ACC
		&& pc_q == `LIM_RST_PC) else $error("software reset incomplete");
	noop_a: assert property (accept && op == lim_pkg::OP_NOOP && !bus_wr |=>
		pc_q == $past(pc_q) + 15'h1 && $stable(acc_q) && !mem_wr.valid) else $error("no-op changed state");

endmodule // lim_core

`default_nettype wire

/* verification/lim_core_tb.sv */
// Self-checking bench for the literal and indirect move decoder.
// Assumes the core alone: the bench is the AHB-Lite master and the instruction feed.
`include "lim_map.svh"
`default_nettype none

module lim_core_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk, sys_rst, hsel, hwrite, hreadyout, hresp, instr_valid, instr_ready, soft_rst_pulse;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [13:0] instr_word;
	lim_pkg::lim_wr_s mem_wr;
	int fail_count = 0;
	int compares = 0;
	int cyc = 0;

	// Single slave, so its ready is looped back as the bus ready
	lim_core uut (.mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .instr_valid(instr_valid), .instr_word(instr_word),
		.instr_ready(instr_ready), .mem_wr(mem_wr), .soft_rst_pulse(soft_rst_pulse));

	// 100 MHz clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic end_sim();
		if (fail_count == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Ready is judged at the falling edge, where it has settled, then the rising edge is taken
	task automatic wait_rdy();
		@(negedge mclk);
		while (hreadyout !== 1'b1) @(negedge mclk);
		@(posedge mclk);
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		wait_rdy();
		htrans <= 2'b00;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
	endtask

	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(what, exp, rd);
		chk("hresp", 32'h0, 32'(hresp));
	endtask

	// Issues one word; returns just after the taking edge, when stores show on mem_wr
	task automatic ins(input logic [13:0] w);
		@(posedge mclk);
		instr_valid <= 1'b1;
		instr_word <= w;
		@(negedge mclk);
		while (instr_ready !== 1'b1) @(negedge mclk);
		@(posedge mclk);
		instr_valid <= 1'b0;
		#1;
	endtask

	// Two words on consecutive taking edges; valid stays up between them
	task automatic ins_pair(input logic [13:0] w0, input logic [13:0] w1);
		@(posedge mclk);
		instr_valid <= 1'b1;
		instr_word <= w0;
		@(negedge mclk);
		while (instr_ready !== 1'b1) @(negedge mclk);
		@(posedge mclk);
		instr_word <= w1;
		@(negedge mclk);
		while (instr_ready !== 1'b1) @(negedge mclk);
		@(posedge mclk);
		instr_valid <= 1'b0;
		#1;
	endtask

	task automatic wrchk(input logic ind, input logic [15:0] a, input logic [7:0] d);
		chk("mem_wr", 32'({1'b1, ind, a, d}), 32'(mem_wr));
	endtask

	task automatic t_reset();
		rdchk("ctrl", `LIM_A_CTRL, 32'h1);
		rdchk("reset flag", `LIM_A_PWR, 32'h1);
		rdchk("pc", `LIM_A_PC, 32'h0);
		bus(1'b1, 8'h40, 32'hffff_ffff);
		rdchk("unmapped", 8'h40, 32'h0);
	endtask

	task automatic t_literals();
		bus(1'b1, `LIM_A_STAT, 32'h5a);
		ins(14'h30ff);
		ins(14'h017f);
		ins(14'h31ff);
		rdchk("acc", `LIM_A_ACC, 32'hff);
		rdchk("bank", `LIM_A_BANK, 32'h3f);
		rdchk("page", `LIM_A_PAGE, 32'h7f);
		rdchk("status", `LIM_A_STAT, 32'h5a);
		// Back to back: the store must see the literal loaded one cycle earlier
		ins_pair(14'h3011, 14'h0085);
		wrchk(1'b0, 16'h1f85, 8'h11);
		ins(14'h304f);
		ins(14'h00ff);
		wrchk(1'b0, 16'h1fff, 8'h4f);
	endtask

	// Every mode on both pointers, starting at the edge that forces a wrap
	task automatic t_indirect();
		logic [15:0] p, q, a;
		logic [7:0] ap, ao;
		for (int s = 0; s < 2; s++) begin
			for (int m = 0; m < 4; m++) begin
				p = m[0] ? 16'h0000 : 16'hffff;
				q = m[0] ? p - 16'h1 : p + 16'h1;
				a = m[1] ? p : q;
				ap = 8'(`LIM_A_PTR0 + s * `LIM_A_STEP);
				ao = 8'(`LIM_A_PTR0 + (1 - s) * `LIM_A_STEP);
				bus(1'b1, ap, 32'(p));
				bus(1'b1, ao, 32'h1234);
				ins(14'(32'h10 + s * 4 + m));
				wrchk(1'b1, a, 8'h4f);
				rdchk("pointer", ap, 32'(q));
				rdchk("other pointer", ao, 32'h1234);
			end
		end
		rdchk("status", `LIM_A_STAT, 32'h5a);
	endtask

	task automatic t_relative();
		bus(1'b1, 8'h14, 32'h0010);
		ins(14'h3f60);
		wrchk(1'b1, 16'hfff0, 8'h4f);
		ins(14'h3f5f);
		wrchk(1'b1, 16'h002f, 8'h4f);
		rdchk("pointer", 8'h14, 32'h0010);
		// Pointer 0 still holds the value left by the mode sweep
		ins(14'h3f01);
		wrchk(1'b1, 16'h1235, 8'h4f);
		rdchk("pointer", `LIM_A_PTR0, 32'h1234);
	endtask

	task automatic t_nop();
		logic [14:0] pcv;
		// A stopped core must refuse the instruction stream
		bus(1'b1, `LIM_A_CTRL, 32'h0);
		chk("ready when stopped", 32'h0, 32'(instr_ready));
		bus(1'b1, `LIM_A_CTRL, 32'h1);
		bus(1'b0, `LIM_A_PC, 32'h0);
		pcv = rd[14:0];
		ins(14'h0000);
		chk("nop store", 32'h0, 32'(mem_wr.valid));
		rdchk("pc", `LIM_A_PC, 32'(pcv + 15'h1));
		rdchk("acc", `LIM_A_ACC, 32'h4f);
	endtask

	task automatic t_srst();
		ins(14'h0001);
		chk("reset pulse", 32'h1, 32'(soft_rst_pulse));
		@(posedge mclk);
		#1;
		chk("reset pulse end", 32'h0, 32'(soft_rst_pulse));
		rdchk("reset flag", `LIM_A_PWR, 32'h0);
		rdchk("acc", `LIM_A_ACC, 32'h0);
		rdchk("bank", `LIM_A_BANK, 32'h0);
		rdchk("pointer", 8'h14, 32'h0);
		rdchk("page", `LIM_A_PAGE, 32'h0);
		rdchk("status", `LIM_A_STAT, 32'h0);
		rdchk("pc", `LIM_A_PC, 32'h0);
		rdchk("ctrl", `LIM_A_CTRL, 32'h1);
	endtask

	// Hang guard: a run this long means a handshake never came
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			end_sim();
		end
	end

	// Main sequence
	initial begin
		sys_rst = 1'b1;
		hsel = 1'b0;
		htrans = 2'b00;
		haddr = 32'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		instr_valid = 1'b0;
		instr_word = 14'h0;
		repeat (10) @(posedge mclk);
		sys_rst <= 1'b0;
		t_reset();
		t_literals();
		t_indirect();
		t_relative();
		t_nop();
		t_srst();
		end_sim();
	end
endmodule // lim_core_tb

`default_nettype wire
